/* File: design/nchp_dev.sv */
// controller end: strobe bus, memory port, status registers, leds
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module nchp_dev #(
  parameter int LED_CYC = nchp_pkg::LED_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  nchp_if.dev hp,
  input wire logic [7:0] pkt_evt_i,
  input wire logic [7:0] sys_evt_i,
  input wire logic cmd_busy_i,
  input wire logic rx_i,
  output logic [7:0] cmd_o,
  output logic [7:0] par_o,
  output logic cmd_stb_o,
  output logic irq_o,
  output logic host_led_n_o,
  output logic act_led_n_o
);
  localparam int LCW = $clog2(LED_CYC + 1);

  nchp_pkg::nchp_dev_st_t state_r;
  nchp_pkg::nchp_dev_st_t state_nxt;
  logic strb_cs;
  logic strb_rd;
  logic strb_wr;
  logic qual;
  logic strb_go;
  logic mem_acc;
  logic [3:0] mem_idx;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_dat;
  logic [3:0] addr_r;
  logic [7:0] din_r;
  logic is_wr_r;
  logic [7:0] dout_r;
  logic [31:0] mrdata_r;
  logic [7:0] par_r;
  logic [7:0] cmd_r;
  logic cmd_stb_r;
  logic [7:0] pmsk_r;
  logic [7:0] smsk_r;
  logic [7:0] psts_r;
  logic [7:0] ssts_r;
  logic irq_r;
  logic [LCW-1:0] led_cnt_r;
  logic act_led_n_r;
  logic [7:0] rmap [16];

  // one decode for all three strobe pins keeps the polarity rule in one place
  function automatic logic pin_on(input logic pin, input logic pol);
    return ~(pin ^ pol);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strobe qualification
  // pins are active when they equal the polarity strap
  assign strb_cs = pin_on(hp.cs, hp.polarity); // see R1
  assign strb_rd = pin_on(hp.rd, hp.polarity); // see R1
  assign strb_wr = pin_on(hp.wr, hp.polarity); // see R1
  assign qual = strb_cs & (strb_rd | strb_wr); // see R2
  assign mem_acc = hp.en; // see R8
  assign mem_idx = hp.maddr[nchp_pkg::IDX_LSB +: nchp_pkg::IDX_W]; // see R10
  // memory port wins a collision; the strobe access simply waits in acc
  assign strb_go = (state_r == nchp_pkg::DST_ACC) & ~mem_acc;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      nchp_pkg::DST_IDLE: if (qual) state_nxt = nchp_pkg::DST_ACC; // see R21
      nchp_pkg::DST_ACC: if (~mem_acc) state_nxt = nchp_pkg::DST_DONE; // see R5
      nchp_pkg::DST_DONE: if (~strb_rd & ~strb_wr) state_nxt = nchp_pkg::DST_IDLE; // see R4
      default: state_nxt = nchp_pkg::DST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= nchp_pkg::DST_IDLE; // see R15
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_r <= 4'h0;
      din_r <= nchp_pkg::RST_BYTE;
      is_wr_r <= 1'b0;
    end
    else if (state_r == nchp_pkg::DST_IDLE && qual)
    begin
      addr_r <= hp.addr; // see R7
      din_r <= hp.din; // see R6
      is_wr_r <= strb_wr;
    end
  end

  assign hp.busy = (state_r != nchp_pkg::DST_IDLE); // see R4
  assign hp.rw_end = (state_r == nchp_pkg::DST_DONE); // see R5

  ////////////////////////////////////////////////////////////////////////////
  // shared write port
  assign wr_en = (mem_acc & (|hp.we)) | (strb_go & is_wr_r); // see R9
  assign wr_idx = mem_acc ? mem_idx : addr_r;
  assign wr_dat = mem_acc ? hp.mwdata[7:0] : din_r; // see R11

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      par_r <= nchp_pkg::RST_BYTE;
      pmsk_r <= nchp_pkg::RST_BYTE;
      smsk_r <= nchp_pkg::RST_BYTE;
    end
    else if (wr_en)
    begin
      if (wr_idx == nchp_pkg::REG_PAR) par_r <= wr_dat;
      if (wr_idx == nchp_pkg::REG_PKT_MSK) pmsk_r <= wr_dat; // see R19
      if (wr_idx == nchp_pkg::REG_SYS_MSK) smsk_r <= wr_dat; // see R19
    end
  end

  // command write issues one pulse carrying the parameter already written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_r <= nchp_pkg::RST_BYTE;
      cmd_stb_r <= 1'b0;
    end
    else
    begin
      cmd_stb_r <= wr_en & (wr_idx == nchp_pkg::REG_CMD);
      if (wr_en && wr_idx == nchp_pkg::REG_CMD) cmd_r <= wr_dat;
    end
  end

  // write one to clear; a new event in the clearing cycle still sets
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      psts_r <= nchp_pkg::RST_BYTE;
      ssts_r <= nchp_pkg::RST_BYTE;
    end
    else
    begin
      psts_r <= (psts_r & ~((wr_en && wr_idx == nchp_pkg::REG_PKT_STS) ? wr_dat : 8'h00))
        | pkt_evt_i; // see R18
      ssts_r <= (ssts_r & ~((wr_en && wr_idx == nchp_pkg::REG_SYS_STS) ? wr_dat : 8'h00))
        | sys_evt_i; // see R18
    end
  end

  // one cycle from status to pin keeps re-assertion well under a microsecond
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_r <= 1'b0;
    else
      irq_r <= (|(psts_r & pmsk_r)) | (|(ssts_r & smsk_r)); // see R20 R17 R19
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side
  always_comb
  begin
    for (int i = 0; i < 16; i++) rmap[i] = 8'h00;
    rmap[nchp_pkg::REG_PAR] = par_r;
    rmap[nchp_pkg::REG_CMD] = {7'h00, cmd_busy_i | cmd_stb_r}; // see R16
    rmap[nchp_pkg::REG_PKT_STS] = psts_r;
    rmap[nchp_pkg::REG_SYS_STS] = ssts_r;
    rmap[nchp_pkg::REG_PKT_MSK] = pmsk_r;
    rmap[nchp_pkg::REG_SYS_MSK] = smsk_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dout_r <= nchp_pkg::RST_BYTE;
    else if (strb_go && !is_wr_r)
      dout_r <= rmap[addr_r]; // see R6
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mrdata_r <= 32'h0000_0000;
    else if (mem_acc)
      mrdata_r <= {24'h00_0000, rmap[mem_idx]}; // see R11
  end

  assign hp.dout = dout_r;
  assign hp.mrdata = mrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // indicators
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      led_cnt_r <= '0;
    else if (strb_go || mem_acc)
      led_cnt_r <= LCW'(LED_CYC); // see R12
    else if (led_cnt_r != '0)
      led_cnt_r <= led_cnt_r - 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      act_led_n_r <= 1'b1;
    else
      act_led_n_r <= ~rx_i; // see R13
  end

  // single clock domain throughout, no crossings needed
  assign host_led_n_o = (led_cnt_r == '0); // see R14
  assign act_led_n_o = act_led_n_r;
  assign cmd_o = cmd_r;
  assign par_o = par_r;
  assign cmd_stb_o = cmd_stb_r;
  assign irq_o = irq_r;
endmodule

/* File: design/nchp_host.sv */
// host end: wishbone slave that runs strobe or memory port accesses
`timescale 1ns/10ps
module nchp_host #(
  parameter logic POLARITY = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  output logic ack_o,
  input wire logic irq_i,
  nchp_if.host hp
);
  nchp_pkg::nchp_hst_st_t state_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic go;
  logic [2:0] cnt_r;
  logic cs_r;
  logic rd_r;
  logic wr_r;
  logic [3:0] addr_r;
  logic [7:0] wdat_r;
  logic is_wr_r;
  logic en_r;
  logic [7:0] rdat_r;

  // pin level for an internal active flag under the polarity strap
  function automatic logic pin_lvl(input logic on, input logic pol);
    return ~(on ^ pol);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, answers one cycle after the request
  assign go = cyc_i & stb_i & ~ack_r & we_i & (adr_i == nchp_pkg::HWB_CMD)
    & (&sel_i[1:0]) & (state_r == nchp_pkg::HST_IDLE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= cyc_i & stb_i & ~ack_r;
      dat_r <= 32'h0000_0000;
      if (cyc_i && stb_i && !ack_r && !we_i && adr_i == nchp_pkg::HWB_STS)
      begin
        dat_r[nchp_pkg::HS_BUSY_BIT] <= (state_r != nchp_pkg::HST_IDLE);
        dat_r[nchp_pkg::HS_RDAT_LSB +: 8] <= rdat_r;
        dat_r[nchp_pkg::HS_IRQ_BIT] <= irq_i;
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= nchp_pkg::HST_IDLE;
      cnt_r <= 3'h0;
      cs_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      en_r <= 1'b0;
      addr_r <= 4'h0;
      wdat_r <= 8'h00;
      is_wr_r <= 1'b0;
      rdat_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        nchp_pkg::HST_IDLE:
          if (go)
          begin
            addr_r <= dat_i[nchp_pkg::HC_ADDR_LSB +: 4];
            wdat_r <= dat_i[nchp_pkg::HC_WDAT_LSB +: 8];
            is_wr_r <= dat_i[nchp_pkg::HC_WR_BIT];
            if (dat_i[nchp_pkg::HC_MEM_BIT])
            begin
              en_r <= 1'b1;
              state_r <= nchp_pkg::HST_MEM;
            end
            else
            begin
              cs_r <= 1'b1; // see R2
              cnt_r <= 3'(nchp_pkg::SETUP_CYC - 1);
              state_r <= nchp_pkg::HST_SETUP;
            end
          end
        nchp_pkg::HST_SETUP:
          if (cnt_r == 3'h0)
          begin
            rd_r <= ~is_wr_r; // see R3
            wr_r <= is_wr_r;
            cnt_r <= 3'(nchp_pkg::HOLD_CYC - 1);
            state_r <= nchp_pkg::HST_STRB;
          end
          else
            cnt_r <= cnt_r - 3'h1;
        nchp_pkg::HST_STRB:
          if (cnt_r != 3'h0)
            cnt_r <= cnt_r - 3'h1; // see R3
          else if (hp.rw_end)
          begin
            if (!is_wr_r) rdat_r <= hp.dout; // see R5
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            state_r <= nchp_pkg::HST_REL;
          end
        nchp_pkg::HST_REL:
          // busy is watched, so the fixed idle gap is not needed
          if (!hp.busy)
          begin
            cs_r <= 1'b0;
            state_r <= nchp_pkg::HST_IDLE;
          end
        nchp_pkg::HST_MEM:
        begin
          en_r <= 1'b0;
          state_r <= nchp_pkg::HST_MEMRD;
        end
        nchp_pkg::HST_MEMRD:
        begin
          rdat_r <= hp.mrdata[7:0];
          state_r <= nchp_pkg::HST_IDLE;
        end
        default: state_r <= nchp_pkg::HST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe pin levels follow the polarity strap
  assign hp.polarity = POLARITY;
  assign hp.cs = pin_lvl(cs_r, POLARITY); // see R1
  assign hp.rd = pin_lvl(rd_r, POLARITY);
  assign hp.wr = pin_lvl(wr_r, POLARITY);
  assign hp.addr = addr_r;
  assign hp.din = wdat_r;
  assign hp.en = en_r;
  assign hp.we = (en_r & is_wr_r) ? 4'hf : 4'h0;
  assign hp.maddr = {addr_r, 2'b00};
  assign hp.mwdata = {24'h00_0000, wdat_r};
endmodule

/* File: shared/nchp_if.sv */
// pins between the controller host port and its host
`timescale 1ns/10ps
interface nchp_if #(parameter int MADDR_W = nchp_pkg::MADDR_W);
  logic polarity;
  logic cs;
  logic rd;
  logic wr;
  logic [3:0] addr;
  logic [7:0] din;
  logic [7:0] dout;
  logic busy;
  logic rw_end;
  logic en;
  logic [3:0] we;
  logic [MADDR_W-1:0] maddr;
  logic [31:0] mwdata;
  logic [31:0] mrdata;

  modport dev (
    input polarity, cs, rd, wr, addr, din, en, we, maddr, mwdata,
    output dout, busy, rw_end, mrdata
  );
  modport host (
    output polarity, cs, rd, wr, addr, din, en, we, maddr, mwdata,
    input dout, busy, rw_end, mrdata
  );
endinterface

/* File: shared/nchp_pkg.sv */
// shared constants and types for the network controller host port
// Summary of operation
// R1: polarity input sets strobe active level
// R2: strobe accesses only while select asserted
// R3: host strobe setup 25ns, hold 50ns
// R4: busy high until done and strobe released
// R5: done flag marks completion; host waits
// R6: separate 8-bit write and read buses
// R7: 4-bit address picks one of sixteen registers
// R8: memory port acts only while enabled
// R9: nonzero write enable writes low byte
// R10: memory port ignores two low address bits
// R11: only low data byte is meaningful
// R12: host access led pulses about 3 ms
// R13: activity led follows receive input
// R14: single master clock for all logic
// R15: reset returns all logic to initial state
// R16: parameter then command, one at a time
// R17: new interrupt may follow clear quickly
// R18: service both status registers until zero
// R19: masked events raise no interrupt
// R20: interrupt high while unmasked status set
// R21: busy rises on qualified strobe, holds through
package nchp_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // host strobe timing
  localparam int ADDR_SETUP_NS = 25;
  localparam int STRB_HOLD_NS = 50;
  localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (STRB_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // access led stretch
  localparam int LED_MS = 3;
  localparam int LED_CYC = LED_MS * 1000000 / CLK_PERIOD_NS;
  // register window
  localparam int IDX_W = 4;
  localparam int IDX_LSB = 2;
  localparam int MADDR_W = 6;
  localparam logic [3:0] REG_PAR = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_PKT_STS = 4'h2;
  localparam logic [3:0] REG_SYS_STS = 4'h3;
  localparam logic [3:0] REG_PKT_MSK = 4'h4;
  localparam logic [3:0] REG_SYS_MSK = 4'h5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // host wishbone map
  localparam logic [3:0] HWB_CMD = 4'h0;
  localparam logic [3:0] HWB_STS = 4'h4;
  localparam int HC_WDAT_LSB = 0;
  localparam int HC_ADDR_LSB = 8;
  localparam int HC_WR_BIT = 12;
  localparam int HC_MEM_BIT = 13;
  localparam int HS_BUSY_BIT = 0;
  localparam int HS_RDAT_LSB = 8;
  localparam int HS_IRQ_BIT = 16;

  typedef enum logic [1:0] {
    DST_IDLE = 2'b00,
    DST_ACC = 2'b01,
    DST_DONE = 2'b10
  } nchp_dev_st_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_SETUP = 3'b001,
    HST_STRB = 3'b010,
    HST_REL = 3'b011,
    HST_MEM = 3'b100,
    HST_MEMRD = 3'b101
  } nchp_hst_st_t;
endpackage

/* File: verif/nchp_assertions.sv */
// checker on the pins between the two ends of the host port
`timescale 1ns/10ps
module nchp_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic polarity,
  input wire logic cs,
  input wire logic rd,
  input wire logic wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] din,
  input wire logic busy,
  input wire logic rw_end,
  input wire logic en,
  input wire logic [3:0] we,
  input wire logic [5:0] maddr,
  input wire logic [31:0] mwdata,
  input wire logic [31:0] mrdata
);
  logic cs_on;
  logic strb_on;
  logic [7:0] par_r;
  assign cs_on = (cs == polarity);
  assign strb_on = (rd == polarity) || (wr == polarity);
  // shadow of the parameter byte; ignores a strobe taken while en is high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      par_r <= 8'h00;
    else if (en && (we != 4'h0) && (maddr[5:2] == 4'h0))
      par_r <= mwdata[7:0];
    else if (!busy && cs_on && (wr == polarity) && (addr == 4'h0) && !en)
      par_r <= din;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    !busy && cs_on && strb_on;
  endsequence
  sequence s_par_rd;
    en && (we == 4'h0) && (maddr[5:2] == 4'h0);
  endsequence
  a_busy_on_take: assert property (s_take |=> busy)
    else $error("busy did not rise on a strobe");
  a_no_cs_idle: assert property ((!busy && !cs_on) |=> !busy)
    else $error("access taken without select");
  a_busy_holds: assert property ((busy && strb_on) |=> busy)
    else $error("busy fell while strobe held");
  a_busy_release: assert property ((rw_end && !strb_on) |=> (!busy && !rw_end))
    else $error("busy not released after strobe");
  a_done_bound: assert property (s_take |-> ##[2:30] rw_end)
    else $error("access never completed");
  a_end_busy: assert property (rw_end |-> busy)
    else $error("done without busy");
  a_upper_zero: assert property (mrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_mrd_stable: assert property (!en |=> $stable(mrdata))
    else $error("read data moved without enable");
  a_par_readback: assert property (s_par_rd |=> (mrdata[7:0] == par_r))
    else $error("parameter readback wrong");
endmodule

/* File: verif/nchp_tb_top.sv */
// self-checking bench joining both ends of the host port
`timescale 1ns/10ps
module nchp_tb_top;
  localparam int LED_N = 20;
  logic clk_i;
  logic rst_i;
  logic [3:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic wb_we;
  logic stb;
  logic ack;
  logic [7:0] pkt_evt;
  logic [7:0] sys_evt;
  logic cmd_busy;
  logic rx;
  logic [7:0] cmd;
  logic [7:0] par;
  logic cmd_stb;
  logic irq;
  logic host_led_n;
  logic act_led_n;
  int n_mismatch;
  int tests_run;
  int n_cyc = 0;
  int n_stb = 0;
  logic [31:0] rdat_hi;
  logic ack_hi;
  logic [7:0] cmd_hi;
  logic [7:0] par_hi;
  logic irq_hi;
  logic [31:0] q_hi;
  logic [7:0] rd_hi;
  nchp_if nchp_if_inst ();
  nchp_dev #(.LED_CYC(LED_N)) nchp_dev_inst (.clk_i(clk_i), .rst_i(rst_i),
    .hp(nchp_if_inst.dev), .pkt_evt_i(pkt_evt), .sys_evt_i(sys_evt), .cmd_busy_i(cmd_busy),
    .rx_i(rx), .cmd_o(cmd), .par_o(par), .cmd_stb_o(cmd_stb), .irq_o(irq),
    .host_led_n_o(host_led_n), .act_led_n_o(act_led_n));
  // active low strobes are the less forgiving case
  nchp_host #(.POLARITY(1'b0)) nchp_host_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wdat), .dat_o(rdat), .we_i(wb_we), .sel_i(4'hf), .stb_i(stb), .cyc_i(stb),
    .ack_o(ack), .irq_i(irq), .hp(nchp_if_inst.host));
  nchp_assertions nchp_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
    .polarity(nchp_if_inst.polarity), .cs(nchp_if_inst.cs), .rd(nchp_if_inst.rd),
    .wr(nchp_if_inst.wr), .addr(nchp_if_inst.addr), .din(nchp_if_inst.din),
    .busy(nchp_if_inst.busy), .rw_end(nchp_if_inst.rw_end), .en(nchp_if_inst.en),
    .we(nchp_if_inst.we), .maddr(nchp_if_inst.maddr), .mwdata(nchp_if_inst.mwdata),
    .mrdata(nchp_if_inst.mrdata));
  // second pair with active high strobes, fed the same bus and event stimulus
  nchp_if nchp_if_hi_inst ();
  nchp_dev #(.LED_CYC(LED_N)) nchp_dev_hi_inst (.clk_i(clk_i), .rst_i(rst_i),
    .hp(nchp_if_hi_inst.dev), .pkt_evt_i(pkt_evt), .sys_evt_i(sys_evt), .cmd_busy_i(cmd_busy),
    .rx_i(rx), .cmd_o(cmd_hi), .par_o(par_hi), .cmd_stb_o(), .irq_o(irq_hi),
    .host_led_n_o(), .act_led_n_o());
  nchp_host #(.POLARITY(1'b1)) nchp_host_hi_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wdat), .dat_o(rdat_hi), .we_i(wb_we), .sel_i(4'hf), .stb_i(stb), .cyc_i(stb),
    .ack_o(ack_hi), .irq_i(irq_hi), .hp(nchp_if_hi_inst.host));
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // the whole run needs a few hundred cycles
  always @(posedge clk_i)
  begin
    n_cyc <= n_cyc + 1;
    if (cmd_stb === 1'b1)
      n_stb <= n_stb + 1;
    if (n_cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    adr <= a;
    wb_we <= w;
    wdat <= d;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    q_hi = rdat_hi;
    stb <= 1'b0;
  endtask
  // one device access, then poll until both host ends are idle again
  task automatic acc(input logic m, input logic w, input logic [3:0] i,
    input logic [7:0] d, output logic [7:0] r);
    logic [31:0] q;
    wb(4'h0, 1'b1, {18'h0, m, w, i, d}, q);
    do wb(4'h4, 1'b0, 32'h0, q); while (q[0] !== 1'b0 || q_hi[0] !== 1'b0);
    r = q[15:8];
    rd_hi = q_hi[15:8];
  endtask
  task automatic pulse(input logic [7:0] p, input logic [7:0] s);
    @(posedge clk_i);
    pkt_evt <= p;
    sys_evt <= s;
    @(posedge clk_i);
    pkt_evt <= 8'h00;
    sys_evt <= 8'h00;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] r;
    chk(irq, 1'b0);
    chk(host_led_n, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b0, 1'b0, i[3:0], 8'h00, r);
      chk(r, 8'h00);
    end
  endtask
  task automatic t_regs();
    logic [7:0] r;
    logic [31:0] q;
    acc(1'b0, 1'b1, 4'h0, 8'ha5, r);
    chk(par, 8'ha5);
    chk(par_hi, 8'ha5);
    acc(1'b1, 1'b1, 4'h4, 8'h3c, r);
    acc(1'b0, 1'b0, 4'h4, 8'h00, r);
    chk(r, 8'h3c);
    chk(rd_hi, 8'h3c);
    acc(1'b1, 1'b0, 4'h0, 8'h00, r);
    chk(r, 8'ha5);
    chk(host_led_n, 1'b0);
    repeat (LED_N + 2) @(posedge clk_i);
    chk(host_led_n, 1'b1);
    acc(1'b0, 1'b1, 4'hf, 8'hff, r);
    acc(1'b0, 1'b0, 4'hf, 8'h00, r);
    chk(r, 8'h00);
    wb(4'h8, 1'b0, 32'h0, q);
    chk(q, 32'h0);
  endtask
  task automatic t_cmd();
    logic [7:0] r;
    acc(1'b0, 1'b1, 4'h0, 8'h11, r);
    acc(1'b0, 1'b1, 4'h1, 8'h42, r);
    chk({par, cmd}, 16'h1142);
    chk({par_hi, cmd_hi}, 16'h1142);
    chk(n_stb, 1);
    cmd_busy <= 1'b1;
    acc(1'b0, 1'b0, 4'h1, 8'h00, r);
    chk(r[0], 1'b1);
    cmd_busy <= 1'b0;
    acc(1'b0, 1'b0, 4'h1, 8'h00, r);
    chk(r[0], 1'b0);
  endtask
  task automatic t_irq();
    logic [7:0] r;
    logic [31:0] q;
    acc(1'b0, 1'b1, 4'h4, 8'hfb, r);
    pulse(8'h04, 8'h00);
    acc(1'b0, 1'b0, 4'h2, 8'h00, r);
    chk({r, 7'h0, irq}, 16'h0400);
    acc(1'b0, 1'b1, 4'h4, 8'h04, r);
    wb(4'h4, 1'b0, 32'h0, q);
    chk({irq, q[16]}, 2'b11);
    acc(1'b0, 1'b1, 4'h5, 8'h80, r);
    acc(1'b0, 1'b1, 4'h2, 8'h04, r);
    pulse(8'h00, 8'h80);
    repeat (4) @(posedge clk_i);
    chk(irq, 1'b1);
    chk(irq_hi, 1'b1);
    acc(1'b0, 1'b0, 4'h2, 8'h00, r);
    chk(r, 8'h00);
    acc(1'b0, 1'b0, 4'h3, 8'h00, r);
    chk(r, 8'h80);
    acc(1'b0, 1'b1, 4'h3, 8'h80, r);
    chk(irq, 1'b0);
  endtask
  task automatic t_act();
    @(posedge clk_i);
    rx <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(act_led_n, 1'b0);
    rx <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(act_led_n, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    rst_i = 1'b1;
    adr = 4'h0;
    wdat = 32'h0;
    wb_we = 1'b0;
    stb = 1'b0;
    pkt_evt = 8'h00;
    sys_evt = 8'h00;
    cmd_busy = 1'b0;
    rx = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_cmd();
    t_irq();
    t_act();
    summarize();
  end
endmodule
